// ### design/rwd_top.sv
// Summary of operation
// - 22-stage binary counter advances every system clock
// - four taps: 2^15, 2^17, 2^19, 2^21
// - tap overflow raises nmi and watchdog out
// - reset clears detection time select to 00
// - reset sets enable bit to one
// - disable needs enable cleared, then code B1
// - writing enable one re-enables at once
// - reset route bit, zero after reset
// - routed overflow holds internal reset 22-29 states
// - code 4E clears counter, counting resumes
// - counting starts right after reset release
// - halted in idle one, stop; idle two optional
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module rwd_top (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      srst,
  // avalon-mm slave
  input  wire logic [rwd_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [rwd_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [rwd_pkg::DATA_W-1:0] avs_readdata,
  output logic                           avs_waitrequest,
  // standby mode from the clock controller
  input  wire logic                      idle_one_mode,
  input  wire logic                      idle_two_mode,
  input  wire logic                      stop_mode,
  // watchdog outputs
  output logic                           runaway_irq,
  output logic                           watchdog_out,
  output logic                           internal_reset,
  // maskable interrupt
  output logic                           irq
);
  import rwd_pkg::*;

  typedef struct packed {
    logic                ack;
    logic [DATA_W-1:0]   rdata;
    logic                en;
    logic [SEL_W-1:0]    sel;
    logic                idle_two_run;
    logic                reset_route_en;
    logic                disabled;
    logic [EV_NUM-1:0]   status;
    logic [EV_NUM-1:0]   mask;
    logic                nmi;
    logic                wd_out;
    logic [RCNT_W-1:0]   rst_cnt;
  } rwd_state_t;

  rwd_state_t st;
  rwd_state_t next_st;

  rwd_cnt_if cif ();

  rwd_counter u_counter (
    .clk  (clk),
    .srst (srst),
    .cif  (cif)
  );

  // decode of one register word, used for both reads and writes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  logic               take_wr;
  logic               take_rd;
  logic               wr_low;
  logic [7:0]         wbyte;
  logic               cmd_wr;
  logic               halted;
  logic               running;
  logic               ovf;
  logic               rst_fire;
  logic [EV_NUM-1:0]  ev;
  logic [DATA_W-1:0]  rd_mux;

  // request is taken on the second cycle, when ack is high
  assign take_wr = avs_write & st.ack;
  assign take_rd = avs_read & st.ack;
  assign wr_low  = take_wr & avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];
  assign cmd_wr  = wr_low & hit(avs_address, OFF_CMD);

  // standby gating of the counter
  assign halted  = idle_one_mode | stop_mode | (idle_two_mode & ~st.idle_two_run);
  assign running = ~st.disabled & ~halted;

  assign cif.run   = running;
  assign cif.clear = cmd_wr & (wbyte == CODE_CLEAR);
  assign cif.sel   = st.sel;
  assign ovf       = cif.overflow;

  // a routed overflow starts the internal reset stretch
  assign rst_fire = ovf & st.reset_route_en;

  always_comb begin
    ev         = '0;
    ev[EV_OVF] = ovf;
    ev[EV_RST] = rst_fire;
  end

  // read multiplexer, unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    if (hit(avs_address, OFF_MODE)) begin
      rd_mux[MODE_EN_BIT]                    = st.en;
      rd_mux[MODE_SEL_LSB +: SEL_W]          = st.sel;
      rd_mux[MODE_IDLE_TWO_MODE_BIT]                 = st.idle_two_run;
      rd_mux[MODE_RST_BIT]                   = st.reset_route_en;
    end else if (hit(avs_address, OFF_STAT)) begin
      rd_mux[EV_NUM-1:0] = st.status;
    end else if (hit(avs_address, OFF_MASK)) begin
      rd_mux[EV_NUM-1:0] = st.mask;
    end else if (hit(avs_address, OFF_STATE)) begin
      rd_mux[ST_RUN_BIT]  = running;
      rd_mux[ST_DIS_BIT]  = st.disabled;
      rd_mux[ST_RSTO_BIT] = internal_reset;
    end else if (hit(avs_address, OFF_COUNT)) begin
      rd_mux[CNT_W-1:0] = cif.count;
    end
  end

  always_comb begin
    next_st = st;

    // one wait state on every access, ack drops after the taken edge
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    if ((avs_read & ~st.ack)) begin
      next_st.rdata = rd_mux;
    end

    // watchdog_mode write
    if (wr_low & hit(avs_address, OFF_MODE)) begin
      next_st.en             = wbyte[MODE_EN_BIT];
      next_st.sel            = wbyte[MODE_SEL_LSB +: SEL_W];
      next_st.idle_two_run   = wbyte[MODE_IDLE_TWO_MODE_BIT];
      next_st.reset_route_en = wbyte[MODE_RST_BIT];
      if (wbyte[MODE_EN_BIT]) begin
        next_st.disabled = 1'b0;
      end
    end

    // disable only when enable is already clear; a lone code cannot stop it
    if (cmd_wr & (wbyte == CODE_DISABLE) & ~st.en) begin
      next_st.disabled = 1'b1;
    end

    if (wr_low & hit(avs_address, OFF_MASK)) begin
      next_st.mask = wbyte[EV_NUM-1:0];
    end

    // sticky status: read clears only what the read returned, a same-cycle event wins;
    // an event landing between capture and take would otherwise be lost unseen
    for (int i = 0; i < EV_NUM; i++) begin
      if (ev[i]) begin
        next_st.status[i] = 1'b1;
      end else if (take_rd & hit(avs_address, OFF_STAT) & st.rdata[i]) begin
        next_st.status[i] = 1'b0;
      end
    end

    // nmi and watchdog out pulse once per overflow
    next_st.nmi    = ovf;
    next_st.wd_out = ovf;

    // reset stretch counts down through a fixed number of states
    if (rst_fire) begin
      next_st.rst_cnt = RCNT_W'(RESET_STATES);
    end else if (st.rst_cnt != '0) begin
      next_st.rst_cnt = st.rst_cnt - RCNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st                <= '0;
      st.en             <= RST_EN;
      st.sel            <= RST_SEL;
      st.idle_two_run   <= RST_IDLE_TWO_MODE;
      st.reset_route_en <= RST_ROUTE;
      st.mask           <= RST_MASK;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
  assign avs_readdata    = st.rdata;
  assign runaway_irq     = st.nmi;
  assign watchdog_out    = st.wd_out;
  // the stretch keeps going through srst only if the system holds it off the block
  assign internal_reset  = st.rst_cnt != '0;
  assign irq             = |(st.status & st.mask);

endmodule // rwd_top

// ### design/rwd_pkg.sv
package rwd_pkg;

  // counter geometry
  localparam int unsigned CNT_W      = 22;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned TAP_NUM    = 4;
  localparam int unsigned TAP_BASE   = 15;
  localparam int unsigned TAP_STEP   = 2;

  // avalon-mm register window, byte addresses
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 32;
  localparam logic [4:0]  OFF_MODE   = 5'h00;
  localparam logic [4:0]  OFF_CMD    = 5'h04;
  localparam logic [4:0]  OFF_STAT   = 5'h08;
  localparam logic [4:0]  OFF_MASK   = 5'h0c;
  localparam logic [4:0]  OFF_STATE  = 5'h10;
  localparam logic [4:0]  OFF_COUNT  = 5'h14;

  // watchdog_mode fields
  localparam int unsigned MODE_EN_BIT    = 7;
  localparam int unsigned MODE_SEL_LSB   = 5;
  localparam int unsigned MODE_IDLE_TWO_MODE_BIT = 3;
  localparam int unsigned MODE_RST_BIT   = 2;

  // reset values of watchdog_mode fields
  localparam logic             RST_EN    = 1'b1;
  localparam logic [SEL_W-1:0] RST_SEL   = 2'h0;
  localparam logic             RST_IDLE_TWO_MODE = 1'b0;
  localparam logic             RST_ROUTE = 1'b0;

  // watchdog_command codes
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam logic [7:0] CODE_CLEAR   = 8'h4e;

  // interrupt status / mask layout
  localparam int unsigned EV_NUM      = 2;
  localparam int unsigned EV_OVF      = 0;
  localparam int unsigned EV_RST      = 1;
  localparam logic [EV_NUM-1:0] RST_MASK = 2'h0;

  // state register layout
  localparam int unsigned ST_RUN_BIT  = 0;
  localparam int unsigned ST_DIS_BIT  = 1;
  localparam int unsigned ST_RSTO_BIT = 2;

  // internal reset hold, in system clock states (allowed 22 to 29)
  localparam int unsigned RESET_STATES = 22;
  localparam int unsigned RCNT_W       = 5;

endpackage

// ### design/rwd_cnt_if.sv
`timescale 1ns/1ns
interface rwd_cnt_if;
  import rwd_pkg::*;
  logic                 run;
  logic                 clear;
  logic [SEL_W-1:0]     sel;
  logic                 overflow;
  logic [CNT_W-1:0]     count;

  modport ctrl (output run, output clear, output sel, input overflow, input count);
  modport cnt  (input run, input clear, input sel, output overflow, output count);
endinterface

// ### design/rwd_counter.sv
`timescale 1ns/1ns
module rwd_counter (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // control side
  rwd_cnt_if.cnt    cif
);
  import rwd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } rwd_cnt_state_t;

  rwd_cnt_state_t st;
  rwd_cnt_state_t next_st;

  // all ones below the tap: the next advance carries out of that stage
  function automatic logic tap_full(input logic [CNT_W-1:0] c, input logic [SEL_W-1:0] s);
    logic [CNT_W-1:0] m;
    m = (CNT_W'(1) << (TAP_BASE + TAP_STEP * 32'(s))) - CNT_W'(1);
    return (c & m) == m;
  endfunction

  assign cif.count    = st.count;
  assign cif.overflow = cif.run & ~cif.clear & tap_full(st.count, cif.sel);

  always_comb begin
    next_st = st;
    if (cif.clear) begin
      next_st.count = '0;
    end else if (cif.run) begin
      next_st.count = st.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // rwd_counter

// ### testbench/rwd_top_props.sv
`timescale 1ns/1ns
module rwd_top_props (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       srst,
  // register bus
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [rwd_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  // standby and watchdog outputs
  input wire logic                       idle_one_mode,
  input wire logic                       stop_mode,
  input wire logic                       runaway_irq,
  input wire logic                       watchdog_out,
  input wire logic                       internal_reset
);
  logic [5:0] hold_len;
  logic       req_d;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // cycles of the current reset run; a stuck-high reset trips hold_max_a before the count wraps
  always_ff @(posedge clk) begin
    hold_len <= (srst || !internal_reset) ? 6'h00 : hold_len + 6'h01;
    req_d    <= !srst && (avs_read || avs_write);
  end

  pulse_pair_a: assert property (runaway_irq == watchdog_out)
    else $error("pulse outputs differ");
  pulse_single_a: assert property (runaway_irq |=> !runaway_irq [*8])
    else $error("pulse too long");
  hold_min_a: assert property ($fell(internal_reset) |-> $past(hold_len) >= 6'h15)
    else $error("reset hold short");
  hold_max_a: assert property (hold_len <= 6'h1d)
    else $error("reset hold long");
  route_cause_a: assert property ($rose(internal_reset) |-> watchdog_out)
    else $error("reset without overflow");
  halt_quiet_a: assert property ((idle_one_mode || stop_mode) [*2] |-> !runaway_irq)
    else $error("overflow while halted");
  wait_once_a: assert property ((avs_read || avs_write) && !req_d
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state wrong");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
endmodule // rwd_top_props

bind rwd_top rwd_top_props u_props (.clk, .srst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .idle_one_mode, .stop_mode, .runaway_irq, .watchdog_out, .internal_reset);

// ### testbench/runaway_watchdog_timer_bench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module runaway_watchdog_timer_bench;
  import rwd_pkg::*;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'h1;
  logic [DATA_W-1:0] avs_readdata, a, b;
  logic              avs_waitrequest, runaway_irq, watchdog_out, internal_reset, irq;
  logic              idle_one_mode = 1'b0;
  logic              idle_two_mode = 1'b0;
  logic              stop_mode = 1'b0;
  int                error_cnt = 0;
  int                comparisons = 0;
  int                ticks = 0;
  int                t0, n;
  logic [4:0]        offs [5] = '{OFF_MODE, OFF_MASK, OFF_STAT, OFF_CMD, 5'h18};
  logic [2:0]        stby [4] = '{3'h4, 3'h1, 3'h2, 3'h2};
  logic [7:0]        hmod [4] = '{8'h80, 8'h80, 8'h80, 8'h88};

  always #20 clk = ~clk;
  always @(posedge clk) ticks <= ticks + 1;

  rwd_top dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .idle_one_mode, .idle_two_mode,
    .stop_mode, .runaway_irq, .watchdog_out, .internal_reset, .irq);

  task automatic bus(input logic r, input logic [4:0] ad, input logic [7:0] d,
                     output logic [DATA_W-1:0] q);
    @(posedge clk);
    avs_address   <= ad;
    avs_read      <= r;
    avs_write     <= !r;
    avs_writedata <= {24'h00_0000, d};
    // no cycle count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    logic [DATA_W-1:0] q;
    bus(1'b0, ad, d, q);
  endtask

  task automatic rd(input logic [4:0] ad, output logic [DATA_W-1:0] q);
    bus(1'b1, ad, 8'h00, q);
  endtask

  // one extra edge so a flag registered from a register update has landed
  task automatic settle;
    @(posedge clk);
    #1;
  endtask

  task end_of_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #3_200_000;
    error_cnt++;
    end_of_test;
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    t0 = ticks;
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], a);
      `CHK("reset read", (i == 0) ? 32'h0000_0080 : 32'h0000_0000, a)
    end
    // a write without its low byte lane must leave the register alone
    avs_byteenable <= 4'h0;
    wr(OFF_MASK, 8'h03);
    rd(OFF_MASK, a);
    `CHK("lane off", 32'h0000_0000, a)
    avs_byteenable <= 4'h1;
    wr(OFF_MASK, 8'h03);
    wr(OFF_MODE, 8'h84);
    do settle; while (runaway_irq !== 1'b1 && ticks - t0 < 40000);
    `CHK("first overflow", 32768, ticks - t0)
    `CHK("watchdog out", 1'b1, watchdog_out)
    n = 0;
    while (internal_reset === 1'b1 && n < 40) begin
      n++;
      settle;
    end
    `CHK("reset hold", 1'b1, n >= 22 && n <= 29)
    wr(OFF_MASK, 8'h00);
    settle;
    `CHK("irq masked", 1'b0, irq)
    wr(OFF_MASK, 8'h03);
    settle;
    `CHK("irq set", 1'b1, irq)
    rd(OFF_STAT, a);
    `CHK("status", 32'h0000_0003, a)
    settle;
    `CHK("irq cleared", 1'b0, irq)
    wr(OFF_CMD, CODE_CLEAR);
    rd(OFF_COUNT, a);
    `CHK("count cleared", 1'b1, a < 8)
    wr(OFF_CMD, 8'h00);
    wr(OFF_CMD, CODE_DISABLE);
    rd(OFF_STATE, a);
    `CHK("state", 32'h0000_0001, a)
    rd(OFF_COUNT, a);
    `CHK("count kept", 1'b1, a >= 8)
    wr(OFF_MODE, 8'h00);
    rd(OFF_STATE, a);
    `CHK("state", 32'h0000_0001, a)
    wr(OFF_CMD, CODE_DISABLE);
    rd(OFF_STATE, a);
    `CHK("state", 32'h0000_0002, a)
    rd(OFF_COUNT, a);
    rd(OFF_COUNT, b);
    `CHK("frozen", a, b)
    wr(OFF_MODE, 8'h80);
    rd(OFF_STATE, a);
    `CHK("state", 32'h0000_0001, a)
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MODE, hmod[i]);
      @(posedge clk);
      {idle_one_mode, idle_two_mode, stop_mode} <= stby[i];
      rd(OFF_COUNT, a);
      rd(OFF_COUNT, b);
      `CHK("halt", i < 3, a === b)
      @(posedge clk);
      {idle_one_mode, idle_two_mode, stop_mode} <= 3'h0;
    end
    wr(OFF_MODE, 8'he4);
    rd(OFF_MODE, a);
    `CHK("mode", 32'h0000_00e4, a)
    wr(OFF_MODE, 8'ha0);
    wr(OFF_CMD, CODE_CLEAR);
    #1;
    t0 = ticks;
    n = 0;
    while (ticks - t0 < 33000) begin
      settle;
      if (runaway_irq === 1'b1) n++;
    end
    `CHK("slow tap", 0, n)
    rd(OFF_MODE, a);
    `CHK("mode", 32'h0000_00a0, a)
    end_of_test;
  end
endmodule // runaway_watchdog_timer_bench
